// ==== pkg/dlef_pkg.sv ====
// Constants and types for the data link event flag block.
// Assumes one 50 MHz clock and software access over AHB-Lite.
//
// Notes on behaviour
// - Controller 2 sets end-of-reception bit 3 on full message or buffer full.
// - Event flags stay set until software reads their status register or writes one to them.
// - Controller 2 sets frame check error bit 2 on failed frame check.
// - Abort bit 1 sets after seven consecutive ones on incoming link bits.
// - Idle bit 0 sets when the flag octet 0x7E arrives on the link.
// - Start-of-transmission bit 6 sets when the transmitter begins a message.
// - Start-of-reception bit 5 sets when the receiver begins a message.
// - End-of-transmission bit 4 sets when the transmitter finishes a message.
// - Controller 3 bit 7 shows message kind: 0 bit-oriented, 1 message-oriented.
// - Enable bit one lets its event interrupt; zero suppresses; bit 7 reserved.
// - Enable bits map like status bits 6 down to 0.
// - Status 2 at 0x0B16, enable 2 at 0x0B17, status 3 at 0x0B26.
// - Controller 3 has its own start/end flags in bits 6, 5, 4, 3.
package dlef_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] DLEF_IDX_STATUS2 = 12'h0b16;
  localparam logic [11:0] DLEF_IDX_ENABLE2 = 12'h0b17;
  localparam logic [11:0] DLEF_IDX_STATUS3 = 12'h0b26;
  localparam logic [11:0] DLEF_IDX_ENABLE3 = 12'h0b27;
  localparam int          DLEF_ADDR_W      = 14;

  // Field positions, shared by status and enable registers
  localparam int DLEF_BIT_KIND     = 7;
  localparam int DLEF_BIT_TX_BEGIN = 6;
  localparam int DLEF_BIT_RX_BEGIN = 5;
  localparam int DLEF_BIT_TX_DONE  = 4;
  localparam int DLEF_BIT_RX_DONE  = 3;
  localparam int DLEF_BIT_CHK_ERR  = 2;
  localparam int DLEF_BIT_ABORT    = 1;
  localparam int DLEF_BIT_IDLE     = 0;
  localparam int DLEF_NUM_EVENTS   = 7;

  localparam logic [7:0] DLEF_ENABLE_MASK  = 8'h7f;
  localparam logic [7:0] DLEF_FLAG_OCTET   = 8'h7e;
  localparam logic [2:0] DLEF_ABORT_ONES   = 3'h7;
  localparam logic [6:0] DLEF_FLAGS_RESET  = 7'h00;
  localparam logic [7:0] DLEF_ENABLE_RESET = 8'h00;

  // AHB-Lite encodings
  localparam logic [1:0] DLEF_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] DLEF_HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0] {
    DLEF_REG_NONE,
    DLEF_REG_STATUS,
    DLEF_REG_ENABLE
  } dlef_reg_kind_t;

endpackage

// ==== pkg/dlef_chan_if.sv ====
// Signals between the register front end and one link channel.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface dlef_chan_if;
  import dlef_pkg::*;
  logic                       txBegin;
  logic                       rxBegin;
  logic                       txDone;
  logic                       rxDone;
  logic                       chkErr;
  logic                       linkBit;
  logic                       linkBitValid;
  logic                       msgKind;
  logic                       readClear;
  logic                       writeClear;
  logic [7:0]                 wdata;
  logic                       enableWrite;
  logic [7:0]                 status;
  logic [7:0]                 enable;
  logic                       irq;

  modport front (
    output txBegin, rxBegin, txDone, rxDone, chkErr, linkBit, linkBitValid,
    output msgKind, readClear, writeClear, wdata, enableWrite,
    input  status, enable, irq
  );
  modport chan (
    input  txBegin, rxBegin, txDone, rxDone, chkErr, linkBit, linkBitValid,
    input  msgKind, readClear, writeClear, wdata, enableWrite,
    output status, enable, irq
  );
endinterface

// ==== src/dlef_link_channel.sv ====
// Event flags, enable mask and link bit monitor of one data link controller.
// Assumes event strobes and link bits are one-cycle pulses on sys_clk.
`timescale 1ns/1ps
module dlef_link_channel
  import dlef_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  dlef_chan_if.chan ch
);

  logic [6:0] flags_q;
  logic [6:0] flags_d;
  logic [6:0] events;
  logic [7:0] enable_q;
  logic       kind_q;
  logic [7:0] shift_q;
  logic [7:0] shiftNext;
  logic [2:0] ones_q;
  logic       abortHit;
  logic       idleHit;

  ////////////////////////////////////////////////////////////////////////////
  // Link bit monitor
  assign shiftNext = {shift_q[6:0], ch.linkBit};
  assign idleHit   = ch.linkBitValid && (shiftNext == DLEF_FLAG_OCTET);
  assign abortHit  = ch.linkBitValid && ch.linkBit
                     && (ones_q == DLEF_ABORT_ONES - 3'h1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= 8'h00;
    end else if (ch.linkBitValid) begin
      shift_q <= shiftNext;
    end
  end

  // Saturates at seven so a long run of ones raises the flag only once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ones_q <= 3'h0;
    end else if (ch.linkBitValid) begin
      if (!ch.linkBit) begin
        ones_q <= 3'h0;
      end else if (ones_q != DLEF_ABORT_ONES) begin
        ones_q <= ones_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a new event beats a clear in the same cycle
  always_comb begin
    events                    = '0;
    events[DLEF_BIT_TX_BEGIN] = ch.txBegin;
    events[DLEF_BIT_RX_BEGIN] = ch.rxBegin;
    events[DLEF_BIT_TX_DONE]  = ch.txDone;
    events[DLEF_BIT_RX_DONE]  = ch.rxDone;
    events[DLEF_BIT_CHK_ERR]  = ch.chkErr;
    events[DLEF_BIT_ABORT]    = abortHit;
    events[DLEF_BIT_IDLE]     = idleHit;
    flags_d = flags_q;
    if (ch.readClear) begin
      flags_d = '0;
    end else if (ch.writeClear) begin
      flags_d = flags_q & ~ch.wdata[6:0];
    end
    flags_d = flags_d | events;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= DLEF_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Kind of the latest received message
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      kind_q <= 1'b0;
    end else if (ch.rxDone) begin
      kind_q <= ch.msgKind;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= DLEF_ENABLE_RESET;
    end else if (ch.enableWrite) begin
      enable_q <= ch.wdata & DLEF_ENABLE_MASK;
    end
  end

  assign ch.status = {kind_q, flags_q};
  assign ch.enable = enable_q;
  assign ch.irq    = |(flags_q & enable_q[6:0]);

endmodule

// ==== src/dlef_flags.sv ====
// Top of the data link event flag block: AHB-Lite slave and two channels.
// Assumes the controllers and framer logic share sys_clk with the bus.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module dlef_flags
  import dlef_pkg::*;
(
  input  wire  logic                   sys_clk,
  input  wire  logic                   rst_b,
  // AHB-Lite slave
  input  wire  logic                   hsel,
  input  wire  logic [DLEF_ADDR_W-1:0] haddr,
  input  wire  logic [1:0]             htrans,
  input  wire  logic                   hwrite,
  input  wire  logic [2:0]             hsize,
  input  wire  logic                   hready,
  input  wire  logic [31:0]            hwdata,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // Controller 2 events
  input  wire  logic                   link2TxBegin,
  input  wire  logic                   link2RxBegin,
  input  wire  logic                   link2TxDone,
  input  wire  logic                   link2RxDone,
  input  wire  logic                   link2ChkErr,
  input  wire  logic                   link2Bit,
  input  wire  logic                   link2BitValid,
  input  wire  logic                   link2MsgKind,
  // Controller 3 events
  input  wire  logic                   link3TxBegin,
  input  wire  logic                   link3RxBegin,
  input  wire  logic                   link3TxDone,
  input  wire  logic                   link3RxDone,
  input  wire  logic                   link3ChkErr,
  input  wire  logic                   link3Bit,
  input  wire  logic                   link3BitValid,
  input  wire  logic                   link3MsgKind,
  // Interrupt
  output logic                         irq
);

  dlef_chan_if ch2 ();
  dlef_chan_if ch3 ();

  logic           addrValid;
  logic [11:0]    addrIdx;
  logic           wrPend_q;
  logic [11:0]    wrIdx_q;
  logic [31:0]    hrdata_q;
  logic           irq_q;
  logic           hreadyout_q;
  logic           hresp_q;
  logic [7:0]     readByte;

  // Register index of a byte address; alignment is checked in addrValid
  function automatic logic [11:0] wordIndex(logic [DLEF_ADDR_W-1:0] a);
    return a[DLEF_ADDR_W-1:2];
  endfunction

  function automatic dlef_reg_kind_t regKind(logic [11:0] idx,
                                             logic [11:0] sIdx,
                                             logic [11:0] eIdx);
    if (idx == sIdx) begin
      return DLEF_REG_STATUS;
    end else if (idx == eIdx) begin
      return DLEF_REG_ENABLE;
    end
    return DLEF_REG_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address phase decode
  assign addrValid = hsel && hready && (htrans == DLEF_HTRANS_NONSEQ)
                     && (hsize == DLEF_HSIZE_WORD) && (haddr[1:0] == 2'b00);
  assign addrIdx   = wordIndex(haddr);

  always_comb begin
    readByte = 8'h00;
    if (regKind(addrIdx, DLEF_IDX_STATUS2, DLEF_IDX_ENABLE2)
        == DLEF_REG_STATUS) begin
      // Controller 2 kind bit is not part of this register set
      readByte = {1'b0, ch2.status[6:0]};
    end else if (regKind(addrIdx, DLEF_IDX_STATUS2, DLEF_IDX_ENABLE2)
                 == DLEF_REG_ENABLE) begin
      readByte = ch2.enable;
    end else if (regKind(addrIdx, DLEF_IDX_STATUS3, DLEF_IDX_ENABLE3)
                 == DLEF_REG_STATUS) begin
      readByte = ch3.status;
    end else if (regKind(addrIdx, DLEF_IDX_STATUS3, DLEF_IDX_ENABLE3)
                 == DLEF_REG_ENABLE) begin
      readByte = ch3.enable;
    end
  end

  // Read data is captured at the address edge, the same edge that clears
  // the flags, so software sees every event exactly once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addrValid && !hwrite) begin
      hrdata_q <= {24'h00_0000, readByte};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_q <= 1'b0;
      wrIdx_q  <= 12'h000;
    end else begin
      wrPend_q <= addrValid && hwrite;
      wrIdx_q  <= addrIdx;
    end
  end

  // Zero wait state, always OKAY
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel hookup
  assign ch2.txBegin      = link2TxBegin;
  assign ch2.rxBegin      = link2RxBegin;
  assign ch2.txDone       = link2TxDone;
  assign ch2.rxDone       = link2RxDone;
  assign ch2.chkErr       = link2ChkErr;
  assign ch2.linkBit      = link2Bit;
  assign ch2.linkBitValid = link2BitValid;
  assign ch2.msgKind      = link2MsgKind;
  assign ch2.readClear    = addrValid && !hwrite
                            && (addrIdx == DLEF_IDX_STATUS2);
  assign ch2.writeClear   = wrPend_q && (wrIdx_q == DLEF_IDX_STATUS2);
  assign ch2.enableWrite  = wrPend_q && (wrIdx_q == DLEF_IDX_ENABLE2);
  assign ch2.wdata        = hwdata[7:0];

  assign ch3.txBegin      = link3TxBegin;
  assign ch3.rxBegin      = link3RxBegin;
  assign ch3.txDone       = link3TxDone;
  assign ch3.rxDone       = link3RxDone;
  assign ch3.chkErr       = link3ChkErr;
  assign ch3.linkBit      = link3Bit;
  assign ch3.linkBitValid = link3BitValid;
  assign ch3.msgKind      = link3MsgKind;
  assign ch3.readClear    = addrValid && !hwrite
                            && (addrIdx == DLEF_IDX_STATUS3);
  assign ch3.writeClear   = wrPend_q && (wrIdx_q == DLEF_IDX_STATUS3);
  assign ch3.enableWrite  = wrPend_q && (wrIdx_q == DLEF_IDX_ENABLE3);
  assign ch3.wdata        = hwdata[7:0];

  dlef_link_channel u_chan2 (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .ch      (ch2.chan)
  );

  dlef_link_channel u_chan3 (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .ch      (ch3.chan)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: one cycle behind the flags so the output is a flop
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ch2.irq || ch3.irq;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign irq       = irq_q;

endmodule

// ==== verif/dlef_link_peer.sv ====
// Remote link terminal model: event strobes and link bits, two channels.
// Assumes callers use its tasks from one process on sys_clk.
`timescale 1ns/1ps
module dlef_link_peer (
  input  wire logic       sys_clk,
  output logic [1:0][4:0] ev,
  output logic [1:0]      bitv,
  output logic [1:0]      val,
  output logic [1:0]      kind
);
  initial begin
    ev = '0;
    bitv = 2'h2;
    val = 2'h0;
    kind = 2'h0;
  end
  task automatic pulse(input int c, input logic [4:0] v, input logic k);
    @(posedge sys_clk);
    ev[c] <= v;
    kind[c] <= k;
    @(posedge sys_clk);
    ev[c] <= 5'h00;
  endtask
  task automatic bits(input int c, input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      bitv[c] <= v[i];
      val[c] <= 1'b1;
    end
    @(posedge sys_clk);
    val[c] <= 1'b0;
    // Idle line shows the inverse so stale data never looks valid
    bitv[c] <= ~v[n-1];
  endtask
endmodule

// ==== verif/dlef_flags_properties.sv ====
// Port-level properties of the data link event flag block.
// Assumes hready is fed back from hreadyout, as with one slave.
`timescale 1ns/1ps
module dlef_flags_properties
  import dlef_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  input wire logic                   hsel,
  input wire logic [DLEF_ADDR_W-1:0] haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic                   irq
);
  localparam logic [13:0] A_ST2 = {DLEF_IDX_STATUS2, 2'b00};
  localparam logic [13:0] A_EN2 = {DLEF_IDX_ENABLE2, 2'b00};
  localparam logic [13:0] A_ST3 = {DLEF_IDX_STATUS3, 2'b00};
  localparam logic [13:0] A_EN3 = {DLEF_IDX_ENABLE3, 2'b00};
  logic rTake, wTake, mapped;
  assign rTake = hsel && hready && htrans == DLEF_HTRANS_NONSEQ && !hwrite;
  assign wTake = hsel && hready && htrans == DLEF_HTRANS_NONSEQ && hwrite;
  assign mapped = haddr inside {A_ST2, A_EN2, A_ST3, A_EN3};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////
  a_bus_okay:
    assert property (hresp == 1'b0) else $error("hresp not OKAY");
  a_always_ready:
    assert property (hreadyout) else $error("hreadyout low");
  a_upper_zero:
    assert property (hrdata[31:8] == 24'h00_0000) else $error("upper set");
  a_reset_quiet:
    assert property (!$past(rst_b) |-> !irq && hrdata == 32'h0)
      else $error("not quiet after reset");
  // Flags only clear by access, so a falling request needs a bus cause
  a_irq_drop:
    assert property ($fell(irq) |-> $past(rTake, 2) || $past(wTake, 3))
      else $error("irq fell with no access");
  a_read_stable:
    assert property (!$past(rTake) |-> $stable(hrdata))
      else $error("hrdata moved without read");
  a_unmapped_zero:
    assert property ($past(rTake && !mapped) |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
  a_reserved_zero:
    assert property ($past(rTake && haddr != A_ST3) |-> !hrdata[7])
      else $error("reserved bit set");
  c_irq_rise: cover property ($rose(irq));
  c_irq_fall: cover property ($fell(irq));
  c_read_st3: cover property (rTake && haddr == A_ST3);
endmodule
bind dlef_flags dlef_flags_properties u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq)
);

// ==== verif/data_link_event_flags_tb.sv ====
// Self-checking bench for the data link event flag block.
// Assumes a zero-wait AHB-Lite slave and the link peer model.
`timescale 1ns/1ps
module data_link_event_flags_tb;
  import dlef_pkg::*;
  logic                   sys_clk, rst_b, hsel, hwrite, hreadyout;
  logic                   hresp, irq;
  logic [DLEF_ADDR_W-1:0] haddr;
  logic [1:0]             htrans;
  logic [31:0]            hwdata, hrdata, rd;
  wire logic              hready;
  logic [1:0][4:0]        ev;
  logic [1:0]             bitv, val, kind;
  logic [7:0]             m;
  logic [4:0]             e;
  int                     c, errCount, samplesChecked;
  logic [11:0] stIdx [2] = '{DLEF_IDX_STATUS2, DLEF_IDX_STATUS3};
  logic [11:0] enIdx [2] = '{DLEF_IDX_ENABLE2, DLEF_IDX_ENABLE3};
  assign hready = hreadyout;
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  dlef_link_peer peer (.sys_clk(sys_clk), .ev(ev), .bitv(bitv),
    .val(val), .kind(kind));
  dlef_flags DUT (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(DLEF_HSIZE_WORD), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .link2TxBegin(ev[0][4]), .link2RxBegin(ev[0][3]),
    .link2TxDone(ev[0][2]), .link2RxDone(ev[0][1]),
    .link2ChkErr(ev[0][0]), .link2Bit(bitv[0]),
    .link2BitValid(val[0]), .link2MsgKind(kind[0]),
    .link3TxBegin(ev[1][4]), .link3RxBegin(ev[1][3]),
    .link3TxDone(ev[1][2]), .link3RxDone(ev[1][1]),
    .link3ChkErr(ev[1][0]), .link3Bit(bitv[1]),
    .link3BitValid(val[1]), .link3MsgKind(kind[1]), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] expSt(input logic k, input logic [4:0] v);
    return {k, v, 2'b00};
  endfunction
  function automatic logic expIrq(input logic [7:0] en, input logic [4:0] v);
    return |(en[6:2] & v);
  endfunction
  task automatic conclude();
    if (errCount == 0 && samplesChecked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    samplesChecked++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", n, x, g);
      errCount++;
    end
  endtask
  task automatic wrdy();
    int t;
    for (t = 0; t < 50; t++) begin
      @(posedge sys_clk);
      if (hready === 1'b1) break;
    end
    if (t == 50) begin
      errCount++;
      conclude();
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] idx,
                     input logic [7:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= DLEF_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {idx, 2'b00};
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    wrdy();
    rd = hrdata;
  endtask
  task automatic rdChk(input logic [11:0] idx, input logic [7:0] x);
    ahb(1'b0, idx, 8'h00);
    chk("hrdata", {24'h00_0000, x}, rd);
  endtask
  // Looked at after the edge's updates have landed
  task automatic irqChk(input logic x);
    @(posedge sys_clk);
    #1;
    chk("irq", {31'h0, x}, {31'h0, irq});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    void'($urandom(32'he17b));
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (c = 0; c < 2; c++) begin
      rdChk(stIdx[c], 8'h00);
      rdChk(enIdx[c], 8'h00);
      m = 8'($urandom());
      ahb(1'b1, enIdx[c], m);
      rdChk(enIdx[c], m & DLEF_ENABLE_MASK);
    end
    rdChk(12'h0b18, 8'h00);
    // First two passes raise all five strobe events with all enables off
    for (int i = 0; i < 16; i++) begin
      c = i % 2;
      m = (i < 2) ? 8'h00 : 8'($urandom());
      e = (i < 2) ? 5'h1f : 5'($urandom());
      ahb(1'b1, enIdx[c], m);
      peer.pulse(c, e, 1'b0);
      irqChk(expIrq(m, e));
      rdChk(stIdx[c], expSt(1'b0, e));
      irqChk(1'b0);
      rdChk(stIdx[c], 8'h00);
    end
    for (c = 0; c < 2; c++) begin
      ahb(1'b1, enIdx[c], 8'h03);
      peer.bits(c, DLEF_FLAG_OCTET, 8);
      irqChk(1'b1);
      peer.pulse(c, 5'h02, 1'b0);
      rdChk(stIdx[c], 8'h09);
      peer.bits(c, 8'hff, 7);
      rdChk(stIdx[c], 8'h02);
    end
    peer.pulse(1, 5'h02, 1'b1);
    rdChk(stIdx[1], 8'h88);
    rdChk(stIdx[1], 8'h80);
    peer.pulse(1, 5'h02, 1'b0);
    rdChk(stIdx[1], 8'h08);
    peer.pulse(0, 5'h02, 1'b1);
    rdChk(stIdx[0], 8'h08);
    // Software sees the start event before the end event, as a refill would
    peer.pulse(0, 5'h10, 1'b0);
    rdChk(stIdx[0], 8'h40);
    peer.pulse(0, 5'h04, 1'b0);
    rdChk(stIdx[0], 8'h10);
    // Write-one-clear drops only the bits written as one
    peer.pulse(0, 5'h1f, 1'b0);
    ahb(1'b1, stIdx[0], 8'h54);
    rdChk(stIdx[0], 8'h28);
    ahb(1'b1, enIdx[0], 8'hff);
    peer.pulse(1, 5'h02, 1'b1);
    peer.pulse(0, 5'h1f, 1'b0);
    irqChk(1'b1);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    irqChk(1'b0);
    rdChk(stIdx[0], 8'h00);
    rdChk(enIdx[0], 8'h00);
    rdChk(stIdx[1], 8'h00);
    conclude();
  end
endmodule
